// >>> logic/mss_pkg.sv
package mss_pkg;
	// image geometry
	localparam int IMG_BITS          = 64;
	localparam int OFS_ERR_PRESENT   = 0;
	localparam int OFS_PLC_ACTIVE    = 1;
	localparam int OFS_NEW_CONFIG    = 2;
	localparam int OFS_SERVO1_INPUTS = 4;
	localparam int OFS_SERVO2_INPUTS = 8;
	localparam int OFS_AUX3_INPUTS   = 12;
	localparam int OFS_SERVO1_AXIS   = 16;
	localparam int OFS_SERVO2_AXIS   = 32;
	localparam int OFS_AUX3_ENABLED  = 48;
	localparam int OFS_AUX3_POSVALID = 49;
	localparam int OFS_AUX3_STROBE1  = 54;
	localparam int OFS_AUX3_STROBE2  = 55;
	localparam int OFS_AUX3_EXTRA    = 58;
	localparam int OFS_AUX4_INPUTS   = 60;
	// status and command block sizes per mode
	localparam logic [6:0] STATUS_WORDS_STD = 7'h28;
	localparam logic [6:0] STATUS_WORDS_FOL = 7'h32;
	localparam logic [6:0] STATUS_WORDS_EXT = 7'h40;
	localparam logic [3:0] CMD_WORDS_STD    = 4'h6;
	localparam logic [3:0] CMD_WORDS_FOL    = 4'h9;
	localparam logic [3:0] CMD_WORDS_EXT    = 4'hC;
	localparam logic [7:0] CMD_CLEAR_NEWCFG = 8'h49;
	localparam logic [63:0] IMG_RESET       = 64'h0;
	localparam logic [3:0] ERR_CODE_NONE    = 4'h0;

	typedef enum logic [1:0] {
		MSS_MODE_STD = 2'b00,
		MSS_MODE_FOL = 2'b01,
		MSS_MODE_EXT = 2'b10
	} mss_mode_t;

	typedef enum logic [1:0] {
		MSS_WAIT_IDLE = 2'b00,
		MSS_WAIT_HOLD = 2'b01,
		MSS_WAIT_GO   = 2'b10
	} mss_wait_t;

	// per-servo-axis status, bit 0 lands at the axis base offset
	typedef struct packed {
		logic followVelLimit;
		logic followEnabled;
		logic reserved;
		logic servoReady;
		logic torqueLimit;
		logic errorLimit;
		logic strobe2;
		logic strobe1;
		logic inZone;
		logic moving;
		logic programActive;
		logic driveEnabled;
		logic posValid;
		logic axisEnabled;
	} mss_axis_t;

	// aux axis 3 status
	typedef struct packed {
		logic strobe2;
		logic strobe1;
		logic posValid;
		logic axisEnabled;
	} mss_aux_t;

	// error sources grouped by where they are coded
	typedef struct packed {
		logic [3:0] general;
		logic [3:0] servo1;
		logic [3:0] servo2;
		logic [3:0] aux3;
	} mss_err_t;
endpackage : mss_pkg

// >>> logic/mss_status_image.sv
// Behaviour
// RL1 - sixty-four status bits are delivered to the controller on every sweep
// RL2 - status word block is 40, 50 or 64 words by mode
// RL3 - controller supplies sixty-four discrete command bits every sweep
// RL4 - controller supplies 6, 9 or 12 immediate command words by mode
// RL5 - bit positions are offsets from a configurable status base address
// RL6 - faceplate levels at 04-07, 08-11, 12-15 and 60-63
// RL7 - servo status at 16 and 32 in fixed order; aux 3 at 48,49,54,55,58
// RL8 - error-present flag at offset 00 set on any detected error
// RL9 - axis errors in axis code words, others in module status code; outside follower mode aux 3 errors go to the module code
// RL10 - only clear-error command clears error flag and error code words
// RL11 - clear-error leaves flag set while the cause is still present
// RL12 - controller-control-active flag at offset 01 stays set
// RL13 - new-configuration flag at offset 02 set on reset or new configuration
// RL14 - new-configuration flag cleared only by immediate command 49h
// RL15 - controller clears new-configuration flag, then watches it and resends
// RL16 - faceplate status bits follow the current external input levels
// RL17 - wait and jump test only eight servo inputs and four control outputs
// RL18 - follower trigger selectable from eight servo and four aux 3 inputs
// RL19 - aux 4 inputs are reported but never used for wait, jump or trigger
// RL20 - a wait command holds axis motion start until the tested bit is true
// RL21 - reserved image positions always read zero
`timescale 1ns/1ps
module mss_status_image #(
	parameter int          STATUS_BASE = 0,
	parameter logic [15:0] SYNC_UNUSED = 16'h0000
) (
	input  wire logic                   ref_clk,
	input  wire logic                   reset,
	input  wire logic                   sweepStrobe,
	input  wire mss_pkg::mss_mode_t     cfgMode,
	input  wire logic                   newConfigLoad,
	input  wire logic                   clearErrorCmd,
	input  wire logic                   immCmdValid,
	input  wire logic [7:0]             immCmdCode,
	input  wire logic [3:0]             controller_driven_control_outputs,
	input  wire logic                   servo1_plus_overtravel_in,
	input  wire logic                   servo1_minus_overtravel_in,
	input  wire logic                   servo1_home_switch_in,
	input  wire logic                   servo1_strobe_level_in,
	input  wire logic                   servo2_plus_overtravel_in,
	input  wire logic                   servo2_minus_overtravel_in,
	input  wire logic                   servo2_home_switch_in,
	input  wire logic                   servo2_strobe_level_in,
	input  wire logic                   aux3_spare_in_a,
	input  wire logic                   aux3_spare_in_b,
	input  wire logic                   aux3_home_switch_in,
	input  wire logic                   aux3_strobe_level_in,
	input  wire logic                   servo1_ready_in,
	input  wire logic                   servo2_ready_in,
	input  wire logic                   aux3_extra_in,
	input  wire logic                   aux4_spare_in_a,
	input  wire logic                   aux4_spare_in_b,
	input  wire logic                   aux4_spare_in_c,
	input  wire logic                   aux4_spare_low_volt_in,
	input  wire mss_pkg::mss_axis_t     servo1Status,
	input  wire mss_pkg::mss_axis_t     servo2Status,
	input  wire mss_pkg::mss_aux_t      aux3Status,
	input  wire mss_pkg::mss_err_t      errCause,
	input  wire logic                   waitStart,
	input  wire logic [3:0]             waitSelect,
	input  wire logic [3:0]             triggerSelect,
	output logic [63:0]                 discreteStatusImage,
	output logic                        imageValid,
	output logic [31:0]                 imageBaseAddr,
	output logic [6:0]                  statusWordCount,
	output logic [3:0]                  cmdWordCount,
	output mss_pkg::mss_err_t           errCodes,
	output logic                        waitHolding,
	output logic                        motionStartOk,
	output logic                        followerTrigger
);
	import mss_pkg::*;

	// pin synchronisers: 19 faceplate levels, two flops before use
	logic [18:0] pinMeta_reg;
	logic [18:0] pinSync_reg;
	logic [18:0] pinRaw;
	assign pinRaw = {aux4_spare_low_volt_in, aux4_spare_in_c, aux4_spare_in_b,
		aux4_spare_in_a, aux3_extra_in, servo2_ready_in, servo1_ready_in,
		aux3_strobe_level_in, aux3_home_switch_in, aux3_spare_in_b,
		aux3_spare_in_a, servo2_strobe_level_in, servo2_home_switch_in,
		servo2_minus_overtravel_in, servo2_plus_overtravel_in,
		servo1_strobe_level_in, servo1_home_switch_in,
		servo1_minus_overtravel_in, servo1_plus_overtravel_in};

	always_ff @(posedge ref_clk) begin
		if (reset) begin
			pinMeta_reg <= 19'h00000;
			pinSync_reg <= 19'h00000;
		end else begin
			pinMeta_reg <= pinRaw;
			pinSync_reg <= pinMeta_reg;
		end
	end

	// synced groups; aux 4 kept apart so no selector can reach it
	logic [3:0] s1In, s2In, a3In, a4In;
	assign s1In = pinSync_reg[3:0];
	assign s2In = pinSync_reg[7:4];
	assign a3In = pinSync_reg[11:8];
	assign a4In = pinSync_reg[18:15]; // RL19

	// mode-dependent block sizes
	function automatic logic [6:0] statusWords(input mss_mode_t m);
		case (m)
			MSS_MODE_STD: statusWords = STATUS_WORDS_STD;
			MSS_MODE_FOL: statusWords = STATUS_WORDS_FOL;
			MSS_MODE_EXT: statusWords = STATUS_WORDS_EXT;
			default:      statusWords = STATUS_WORDS_STD;
		endcase
	endfunction : statusWords

	function automatic logic [3:0] cmdWords(input mss_mode_t m);
		case (m)
			MSS_MODE_STD: cmdWords = CMD_WORDS_STD;
			MSS_MODE_FOL: cmdWords = CMD_WORDS_FOL;
			MSS_MODE_EXT: cmdWords = CMD_WORDS_EXT;
			default:      cmdWords = CMD_WORDS_STD;
		endcase
	endfunction : cmdWords

	always_ff @(posedge ref_clk) begin
		if (reset) begin
			statusWordCount <= STATUS_WORDS_STD;
			cmdWordCount    <= CMD_WORDS_STD;
		end else begin
			statusWordCount <= statusWords(cfgMode); // RL2
			cmdWordCount    <= cmdWords(cfgMode); // RL4
		end
	end

	// error codes: latched per source, only clear-error wipes them
	mss_err_t errCodes_next;
	logic     anyCause;
	assign anyCause = |errCause;
	always_comb begin
		errCodes_next = errCodes;
		if (clearErrorCmd)
			errCodes_next = '0; // RL10
		// a standing cause survives the clear
		if (errCause.general != ERR_CODE_NONE)
			errCodes_next.general = errCause.general; // RL9
		if (errCause.servo1 != ERR_CODE_NONE)
			errCodes_next.servo1 = errCause.servo1; // RL9
		if (errCause.servo2 != ERR_CODE_NONE)
			errCodes_next.servo2 = errCause.servo2; // RL9
		// aux 3 errors keep their own code word only in follower mode; otherwise they go to the general code
		if (cfgMode == MSS_MODE_FOL && errCause.aux3 != ERR_CODE_NONE)
			errCodes_next.aux3 = errCause.aux3; // RL9
		else if (cfgMode != MSS_MODE_FOL && errCause.aux3 != ERR_CODE_NONE)
			errCodes_next.general = errCause.aux3;
	end

	always_ff @(posedge ref_clk) begin
		if (reset)
			errCodes <= '0;
		else
			errCodes <= errCodes_next;
	end

	// error-present flag: set beats clear
	logic errPresent_reg;
	always_ff @(posedge ref_clk) begin
		if (reset)
			errPresent_reg <= 1'b0;
		else if (anyCause)
			errPresent_reg <= 1'b1; // RL8 RL11
		else if (clearErrorCmd)
			errPresent_reg <= 1'b0; // RL10
	end

	// new-config flag; reset counts as a reset command so flag comes up set
	logic newConfig_reg;
	always_ff @(posedge ref_clk) begin
		if (reset)
			newConfig_reg <= 1'b1; // RL13
		else if (newConfigLoad)
			newConfig_reg <= 1'b1; // RL13
		else if (immCmdValid && immCmdCode == CMD_CLEAR_NEWCFG)
			newConfig_reg <= 1'b0; // RL14
	end

	// wait/jump test bit: servo inputs 1-8 then control outputs 9-12 only
	logic [11:0] testable;
	logic        testBit;
	assign testable = {controller_driven_control_outputs, s2In, s1In}; // RL17
	assign testBit  = (waitSelect < 4'hC) ? testable[waitSelect] : 1'b0;

	// follower trigger: servo inputs then aux 3, aux 4 excluded
	logic [11:0] trigSources;
	assign trigSources = {a3In, s2In, s1In}; // RL18
	always_ff @(posedge ref_clk) begin
		if (reset)
			followerTrigger <= 1'b0;
		else
			followerTrigger <= (triggerSelect < 4'hC) ? trigSources[triggerSelect] : 1'b0;
	end

	// wait machine: holds motion start until the selected bit is true
	mss_wait_t waitState_reg, waitState_next;
	always_comb begin
		waitState_next = waitState_reg;
		case (waitState_reg)
			MSS_WAIT_IDLE: if (waitStart) waitState_next = MSS_WAIT_HOLD;
			MSS_WAIT_HOLD: if (testBit) waitState_next = MSS_WAIT_GO; // RL20
			MSS_WAIT_GO:   waitState_next = MSS_WAIT_IDLE;
			default:       waitState_next = MSS_WAIT_IDLE;
		endcase
	end

	always_ff @(posedge ref_clk) begin
		if (reset)
			waitState_reg <= MSS_WAIT_IDLE;
		else
			waitState_reg <= waitState_next;
	end

	assign waitHolding   = (waitState_reg == MSS_WAIT_HOLD);
	assign motionStartOk = (waitState_reg == MSS_WAIT_GO); // RL20

	// assemble the image; reserved positions left at zero
	logic [63:0] image;
	always_comb begin
		image = IMG_RESET; // RL21
		image[OFS_ERR_PRESENT] = errPresent_reg; // RL8
		image[OFS_PLC_ACTIVE]  = 1'b1; // RL12
		image[OFS_NEW_CONFIG]  = newConfig_reg; // RL13
		image[OFS_SERVO1_INPUTS +: 4] = s1In; // RL6 RL16
		image[OFS_SERVO2_INPUTS +: 4] = s2In; // RL6 RL16
		image[OFS_AUX3_INPUTS   +: 4] = a3In; // RL6 RL16
		image[OFS_AUX4_INPUTS   +: 4] = a4In; // RL6 RL19
		image[OFS_SERVO1_AXIS +: 14] = servo1Status; // RL7
		image[OFS_SERVO1_AXIS + 10]  = pinSync_reg[12];
		image[OFS_SERVO1_AXIS + 11]  = 1'b0; // RL21
		image[OFS_SERVO2_AXIS +: 14] = servo2Status; // RL7
		image[OFS_SERVO2_AXIS + 10]  = pinSync_reg[13];
		image[OFS_SERVO2_AXIS + 11]  = 1'b0; // RL21
		image[OFS_AUX3_ENABLED]  = aux3Status.axisEnabled; // RL7
		image[OFS_AUX3_POSVALID] = aux3Status.posValid;
		image[OFS_AUX3_STROBE1]  = aux3Status.strobe1;
		image[OFS_AUX3_STROBE2]  = aux3Status.strobe2;
		image[OFS_AUX3_EXTRA]    = pinSync_reg[14];
	end

	// image captured once per sweep so the controller sees a coherent set
	always_ff @(posedge ref_clk) begin
		if (reset) begin
			discreteStatusImage <= IMG_RESET;
			imageValid          <= 1'b0;
		end else begin
			imageValid <= sweepStrobe;
			if (sweepStrobe)
				discreteStatusImage <= image; // RL1
		end
	end

	assign imageBaseAddr = 32'(STATUS_BASE); // RL5

	// error flag follows a cause within one edge, even across a clear
	property p_err_set;
		@(posedge ref_clk) disable iff (reset)
		anyCause |=> errPresent_reg;
	endproperty
	a_err_set: assert property (p_err_set) else $error("error flag missed cause"); // RL8

	property p_err_hold;
		@(posedge ref_clk) disable iff (reset)
		errPresent_reg && !clearErrorCmd |=> errPresent_reg;
	endproperty
	a_err_hold: assert property (p_err_hold) else $error("error flag cleared unasked"); // RL10

	property p_err_clear;
		@(posedge ref_clk) disable iff (reset)
		clearErrorCmd && !anyCause |=> !errPresent_reg && errCodes == '0;
	endproperty
	a_err_clear: assert property (p_err_clear) else $error("clear error did not clear"); // RL10

	property p_newcfg_clear;
		@(posedge ref_clk) disable iff (reset)
		$fell(newConfig_reg) |-> $past(immCmdValid) && $past(immCmdCode) == CMD_CLEAR_NEWCFG;
	endproperty
	a_newcfg_clear: assert property (p_newcfg_clear) else $error("new config dropped badly"); // RL14

	property p_newcfg_set;
		@(posedge ref_clk) disable iff (reset)
		newConfigLoad |=> newConfig_reg;
	endproperty
	a_newcfg_set: assert property (p_newcfg_set) else $error("new config not flagged"); // RL13

	property p_image_fixed;
		@(posedge ref_clk) disable iff (reset)
		imageValid |-> discreteStatusImage[OFS_PLC_ACTIVE] && !discreteStatusImage[3]
			&& discreteStatusImage[63:59] == {$past(a4In), 1'b0};
	endproperty
	a_image_fixed: assert property (p_image_fixed) else $error("fixed image bits wrong"); // RL12

	// every position that carries nothing; a leak here would confuse controller logic
	localparam logic [63:0] RSV_MASK = 64'h0B3C_C800_C800_0008;

	property p_reserved_zero;
		@(posedge ref_clk) disable iff (reset)
		imageValid |-> (discreteStatusImage & RSV_MASK) == 64'h0;
	endproperty
	a_reserved_zero: assert property (p_reserved_zero) else $error("reserved bit set"); // RL21

	// captured pin levels are the synced levels of the capture edge
	property p_pins_follow;
		@(posedge ref_clk) disable iff (reset)
		imageValid |-> discreteStatusImage[OFS_SERVO1_INPUTS +: 12] == $past({a3In, s2In, s1In});
	endproperty
	a_pins_follow: assert property (p_pins_follow) else $error("pin levels not imaged"); // RL16

	property p_newcfg_hold;
		@(posedge ref_clk) disable iff (reset)
		newConfig_reg && !(immCmdValid && immCmdCode == CMD_CLEAR_NEWCFG) |=> newConfig_reg;
	endproperty
	a_newcfg_hold: assert property (p_newcfg_hold) else $error("new config lost"); // RL14

	property p_trigger;
		@(posedge ref_clk) disable iff (reset)
		triggerSelect < 4'hC |=> followerTrigger == $past(trigSources[triggerSelect]);
	endproperty
	a_trigger: assert property (p_trigger) else $error("trigger source wrong"); // RL18

	property p_wait;
		@(posedge ref_clk) disable iff (reset)
		waitHolding && !testBit |=> !motionStartOk;
	endproperty
	a_wait: assert property (p_wait) else $error("motion started early"); // RL20

	property p_wait_go;
		@(posedge ref_clk) disable iff (reset)
		waitHolding && testBit |=> motionStartOk ##1 !motionStartOk;
	endproperty
	a_wait_go: assert property (p_wait_go) else $error("wait did not release"); // RL20

	property p_sizes;
		@(posedge ref_clk) disable iff (reset)
		cfgMode == MSS_MODE_FOL ##1 1'b1 |-> statusWordCount == STATUS_WORDS_FOL;
	endproperty
	a_sizes: assert property (p_sizes) else $error("status size wrong"); // RL2
endmodule : mss_status_image

// >>> tb/motion_module_status_bit_image_test.sv
`timescale 1ns/1ps
module motion_module_status_bit_image_test;
	import mss_pkg::*;
	localparam int BASE = 256;
	logic        ref_clk = 1'b0;
	logic        reset = 1'b1;
	mss_mode_t   cfgMode = MSS_MODE_STD;
	logic        newConfigLoad = 1'b0;
	logic        clearErrorCmd = 1'b0;
	logic        immCmdValid = 1'b0;
	logic [7:0]  immCmdCode = 8'h00;
	logic [3:0]  ctlOut = 4'h0;
	logic [18:0] pins = 19'h0;
	mss_axis_t   s1 = '0;
	mss_axis_t   s2 = '0;
	mss_aux_t    a3 = '0;
	mss_err_t    errCause = '0;
	logic        waitStart = 1'b0;
	logic [3:0]  waitSelect = 4'h0;
	logic [3:0]  triggerSelect = 4'h0;
	logic        sweepStrobe;
	logic [63:0] image;
	logic        imageValid;
	logic [31:0] imageBaseAddr;
	logic [6:0]  statusWordCount;
	logic [3:0]  cmdWordCount;
	mss_err_t    errCodes;
	logic        waitHolding;
	logic        motionStartOk;
	logic        followerTrigger;
	logic [63:0] scanImage;
	logic [15:0] scanCount;
	logic        expErr = 1'b0;
	logic        expNew = 1'b1;
	int          numErrors = 0;
	int          totalChecks = 0;
	logic [6:0]  swExp [3] = '{STATUS_WORDS_STD, STATUS_WORDS_FOL, STATUS_WORDS_EXT};
	logic [3:0]  cwExp [3] = '{CMD_WORDS_STD, CMD_WORDS_FOL, CMD_WORDS_EXT};

	always #20 ref_clk = ~ref_clk;

	mss_status_image #(.STATUS_BASE(BASE)) uut (
		.ref_clk(ref_clk), .reset(reset), .sweepStrobe(sweepStrobe), .cfgMode(cfgMode),
		.newConfigLoad(newConfigLoad), .clearErrorCmd(clearErrorCmd),
		.immCmdValid(immCmdValid), .immCmdCode(immCmdCode),
		.controller_driven_control_outputs(ctlOut),
		.servo1_plus_overtravel_in(pins[0]), .servo1_minus_overtravel_in(pins[1]),
		.servo1_home_switch_in(pins[2]), .servo1_strobe_level_in(pins[3]),
		.servo2_plus_overtravel_in(pins[4]), .servo2_minus_overtravel_in(pins[5]),
		.servo2_home_switch_in(pins[6]), .servo2_strobe_level_in(pins[7]),
		.aux3_spare_in_a(pins[8]), .aux3_spare_in_b(pins[9]),
		.aux3_home_switch_in(pins[10]), .aux3_strobe_level_in(pins[11]),
		.servo1_ready_in(pins[12]), .servo2_ready_in(pins[13]), .aux3_extra_in(pins[14]),
		.aux4_spare_in_a(pins[15]), .aux4_spare_in_b(pins[16]),
		.aux4_spare_in_c(pins[17]), .aux4_spare_low_volt_in(pins[18]),
		.servo1Status(s1), .servo2Status(s2), .aux3Status(a3), .errCause(errCause),
		.waitStart(waitStart), .waitSelect(waitSelect), .triggerSelect(triggerSelect),
		.discreteStatusImage(image), .imageValid(imageValid),
		.imageBaseAddr(imageBaseAddr), .statusWordCount(statusWordCount),
		.cmdWordCount(cmdWordCount), .errCodes(errCodes), .waitHolding(waitHolding),
		.motionStartOk(motionStartOk), .followerTrigger(followerTrigger)
	);

	mss_plc_model #(.SWEEP_GAP(6)) plc (
		.ref_clk(ref_clk), .reset(reset), .imageValid(imageValid),
		.discreteStatusImage(image), .sweepStrobe(sweepStrobe),
		.scanImage(scanImage), .scanCount(scanCount)
	);

	// image the controller should see, built from what the bench drives
	function automatic logic [63:0] exp_img();
		logic [63:0] e;
		e = 64'h0;
		e[0] = expErr;
		e[1] = 1'b1;
		e[2] = expNew;
		e[15:4] = pins[11:0];
		e[29:16] = s1;
		e[26] = pins[12];
		e[27] = 1'b0;
		e[45:32] = s2;
		e[42] = pins[13];
		e[43] = 1'b0;
		e[49:48] = a3[1:0];
		e[55:54] = a3[3:2];
		e[58] = pins[14];
		e[63:60] = pins[18:15];
		return e;
	endfunction : exp_img

	task automatic check_img(input logic [63:0] got, input logic [63:0] exp);
		totalChecks++;
		if (got !== exp) begin
			numErrors++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : check_img

	task automatic check_val(input logic [31:0] got, input logic [31:0] exp);
		totalChecks++;
		if (got !== exp) begin
			numErrors++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : check_val

	task automatic tick(input int n);
		repeat (n) @(posedge ref_clk);
		#1;
	endtask : tick

	// two sweeps, so synchronised pin levels are surely in the image
	task automatic scan();
		logic [15:0] c;
		c = scanCount;
		for (int i = 0; i < 40 && scanCount - c < 16'h0002; i++)
			tick(1);
		check_img(scanImage, exp_img());
	endtask : scan

	task automatic pulse(input int which);
		@(posedge ref_clk);
		case (which)
			0: clearErrorCmd <= 1'b1;
			1: newConfigLoad <= 1'b1;
			default: waitStart <= 1'b1;
		endcase
		@(posedge ref_clk);
		clearErrorCmd <= 1'b0;
		newConfigLoad <= 1'b0;
		waitStart <= 1'b0;
		#1;
	endtask : pulse

	task automatic imm(input logic [7:0] code);
		@(posedge ref_clk);
		immCmdValid <= 1'b1;
		immCmdCode <= code;
		@(posedge ref_clk);
		immCmdValid <= 1'b0;
		#1;
	endtask : imm

	task automatic reset_dut();
		@(posedge ref_clk);
		reset <= 1'b1;
		repeat (8) @(posedge ref_clk);
		reset <= 1'b0;
		expErr = 1'b0;
		expNew = 1'b1;
		tick(1);
	endtask : reset_dut

	task automatic finish_test();
		$display("checks %0d mismatches %0d", totalChecks, numErrors);
		if (numErrors == 0 && totalChecks > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask : finish_test

	// a hang is cut short well past the expected few hundred cycles
	initial begin
		repeat (5000) @(posedge ref_clk);
		numErrors++;
		$display("watchdog expired at %0t", $time);
		finish_test();
	end

	initial begin
		reset_dut();
		scan();
		check_val(imageBaseAddr, BASE);
		for (int m = 0; m < 3; m++) begin
			@(posedge ref_clk);
			cfgMode <= mss_mode_t'(m[1:0]);
			tick(3);
			check_val({25'h0, statusWordCount}, {25'h0, swExp[m]});
			check_val({28'h0, cmdWordCount}, {28'h0, cwExp[m]});
		end
		$display("test sizes done");
		// reserved and ready fields set high to catch leaks into the image
		for (int p = 0; p < 2; p++) begin
			@(posedge ref_clk);
			pins <= p ? 19'h255A5 : 19'h5AA5A;
			s1 <= p ? 14'h0000 : 14'h3FFF;
			s2 <= p ? 14'h3FFF : 14'h1555;
			a3 <= p ? 4'hA : 4'h5;
			scan();
		end
		$display("test image layout done");
		imm(8'h48);
		scan();
		imm(CMD_CLEAR_NEWCFG);
		expNew = 1'b0;
		scan();
		pulse(1);
		expNew = 1'b1;
		scan();
		$display("test new configuration done");
		@(posedge ref_clk);
		errCause <= 16'h5300;
		expErr = 1'b1;
		scan();
		check_val({16'h0, errCodes}, 32'h5300);
		pulse(0);
		scan();
		check_val({16'h0, errCodes}, 32'h5300);
		@(posedge ref_clk);
		errCause <= 16'h0000;
		imm(CMD_CLEAR_NEWCFG);
		pulse(1);
		scan();
		check_val({16'h0, errCodes}, 32'h5300);
		pulse(0);
		expErr = 1'b0;
		scan();
		check_val({16'h0, errCodes}, 32'h0);
		// outside follower mode an aux 3 fault lands in the module code
		@(posedge ref_clk);
		errCause <= 16'h0027;
		tick(2);
		check_val({16'h0, errCodes}, 32'h7020);
		@(posedge ref_clk);
		errCause <= 16'h0000;
		pulse(0);
		check_val({16'h0, errCodes}, 32'h0);
		$display("test errors done");
		@(posedge ref_clk);
		cfgMode <= MSS_MODE_FOL;
		triggerSelect <= 4'h8;
		pins <= 19'h00100;
		for (int i = 0; i < 6 && followerTrigger !== 1'b1; i++)
			tick(1);
		check_val({31'h0, followerTrigger}, 32'h1);
		@(posedge ref_clk);
		triggerSelect <= 4'h2;
		for (int i = 0; i < 6 && followerTrigger !== 1'b0; i++)
			tick(1);
		check_val({31'h0, followerTrigger}, 32'h0);
		// in follower mode the aux 3 fault keeps its own code word
		@(posedge ref_clk);
		errCause <= 16'h0007;
		tick(2);
		check_val({16'h0, errCodes}, 32'h0007);
		@(posedge ref_clk);
		errCause <= 16'h0000;
		pulse(0);
		check_val({16'h0, errCodes}, 32'h0);
		$display("test follower trigger done");
		@(posedge ref_clk);
		waitSelect <= 4'h9;
		pulse(2);
		tick(5);
		check_val({30'h0, waitHolding, motionStartOk}, 32'h2);
		@(posedge ref_clk);
		ctlOut <= 4'h2;
		for (int i = 0; i < 6 && motionStartOk !== 1'b1; i++)
			tick(1);
		check_val({31'h0, motionStartOk}, 32'h1);
		tick(1);
		check_val({31'h0, motionStartOk}, 32'h0);
		// selects past the control outputs can never release the wait
		@(posedge ref_clk);
		waitSelect <= 4'hC;
		ctlOut <= 4'hF;
		pulse(2);
		tick(8);
		check_val({30'h0, waitHolding, motionStartOk}, 32'h2);
		reset_dut();
		scan();
		$display("test wait done");
		finish_test();
	end
endmodule : motion_module_status_bit_image_test

// >>> tb/mss_plc_model.sv
`timescale 1ns/1ps
module mss_plc_model #(
	parameter int SWEEP_GAP = 6
) (
	ref_clk,
	reset,
	imageValid,
	discreteStatusImage,
	sweepStrobe,
	scanImage,
	scanCount
);
	input  wire logic        ref_clk;
	input  wire logic        reset;
	input  wire logic        imageValid;
	input  wire logic [63:0] discreteStatusImage;
	output logic             sweepStrobe;
	output logic [63:0]      scanImage;
	output logic [15:0]      scanCount;

	logic [7:0] gapCnt;

	// sweep pacing, quiet while reset is held
	always_ff @(posedge ref_clk) begin
		if (reset) begin
			gapCnt <= 8'h00;
			sweepStrobe <= 1'b0;
		end else begin
			sweepStrobe <= (gapCnt == 8'(SWEEP_GAP - 1));
			gapCnt <= (gapCnt == 8'(SWEEP_GAP - 1)) ? 8'h00 : gapCnt + 8'h01;
		end
	end

	// every sweep brings a fresh image back
	always_ff @(posedge ref_clk) begin
		if (reset) begin
			scanImage <= 64'h0;
			scanCount <= 16'h0000;
		end else if (imageValid) begin
			scanImage <= discreteStatusImage;
			scanCount <= scanCount + 16'h0001;
		end
	end
endmodule : mss_plc_model
